// file: sps_suspend_pins.sv
// suspend-time pin override and usb indicator pin b, with axi4-lite regs
// assumes usb state inputs and normal pin drive come from aclk logic;
// only the indicator pin's readback comes from outside and is synchronised
`timescale 1ns/1ps
module sps_suspend_pins #(
  parameter logic [15:0] REVISION = 16'h0000 // arbitrary value
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [sps_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sps_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic usb_suspend,
  input wire logic usb_bus_reset,
  input wire logic usb_configured,
  input wire logic high_power,
  input wire logic [15:0] normal_out,
  input wire logic [15:0] normal_oe,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe,
  input wire logic usb_indicator_pin_b_in,
  output logic usb_indicator_pin_b_out,
  output logic usb_indicator_pin_b_oe
);

  logic [15:0] level_r, level_nxt;
  logic [15:0] mode_r, mode_nxt;
  logic [2:0] indicator_b_select_r, sel_nxt;
  logic [1:0] indicator_b_drive_r, drv_nxt;
  logic aw_hold_r, aw_hold_nxt;
  logic w_hold_r, w_hold_nxt;
  logic [sps_pkg::ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [15:0] wdata_r, wdata_nxt;
  logic [1:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [15:0] pin_out_r, pin_out_nxt;
  logic [15:0] pin_oe_r, pin_oe_nxt;
  logic ind_out_r, ind_out_nxt;
  logic ind_oe_r, ind_oe_nxt;
  logic sy1_r, sy2_r;
  logic susp_act;
  logic ind_active;
  logic ind_level;
  logic do_wr;
  logic [15:0] bmask;
  logic [15:0] sts_word;

  // ready outputs are combinational, valid and data outputs from flops
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready = !w_hold_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign pin_out = pin_out_r;
  assign pin_oe = pin_oe_r;
  assign usb_indicator_pin_b_out = ind_out_r;
  assign usb_indicator_pin_b_oe = ind_oe_r;

  // pin readback crosses from the board, so two flops before any use
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sy1_r <= 1'b0;
      sy2_r <= 1'b0;
    end
    else
    begin
      sy1_r <= usb_indicator_pin_b_in;
      sy2_r <= sy1_r;
    end
  end

  assign susp_act = usb_suspend && mode_r[sps_pkg::EN_BIT];
  assign do_wr = aw_hold_r && w_hold_r && !bvalid_r;
  assign bmask = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign sts_word = {2'b00, sy2_r, indicator_b_select_r,
                     indicator_b_drive_r, 8'h00};

  // write channel capture and register update; prot is not checked
  always_comb
  begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt = w_hold_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    level_nxt = level_r;
    mode_nxt = mode_r;
    sel_nxt = indicator_b_select_r;
    drv_nxt = indicator_b_drive_r;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_hold_nxt = 1'b1;
      wdata_nxt = s_axi_wdata[15:0];
      wstrb_nxt = s_axi_wstrb[1:0];
    end
    if (bvalid_r && s_axi_bready)
      bvalid_nxt = 1'b0;
    if (do_wr)
    begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = sps_pkg::RESP_OKAY;
      // reserved bits are never stored, so they read as zero
      unique case (awaddr_r)
        sps_pkg::ADDR_LEVEL:
          level_nxt = ((level_r & ~bmask) | (wdata_r & bmask))
                      & sps_pkg::PIN_MASK;
        sps_pkg::ADDR_MODE:
          mode_nxt = ((mode_r & ~bmask) | (wdata_r & bmask))
                     & sps_pkg::MODE_MASK;
        sps_pkg::ADDR_REV:
          bresp_nxt = sps_pkg::RESP_OKAY; // read-only, write ignored
        sps_pkg::ADDR_STS:
        begin
          if (wstrb_r[1])
          begin
            sel_nxt = wdata_r[sps_pkg::SEL_LSB +: 3];
            // invalid drive codes are dropped so the pin is never undefined
            if (wdata_r[sps_pkg::DRV_LSB +: 2] == sps_pkg::DRV_OD ||
                wdata_r[sps_pkg::DRV_LSB +: 2] == sps_pkg::DRV_PP)
              drv_nxt = wdata_r[sps_pkg::DRV_LSB +: 2];
          end
        end
        default:
          bresp_nxt = sps_pkg::RESP_SLVERR;
      endcase
    end
  end

  // read channel: one read in flight, data the cycle after the address
  always_comb
  begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rvalid_r && s_axi_rready)
      rvalid_nxt = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = sps_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        sps_pkg::ADDR_LEVEL: rdata_nxt = {16'h0000, level_r};
        sps_pkg::ADDR_MODE: rdata_nxt = {16'h0000, mode_r};
        sps_pkg::ADDR_REV: rdata_nxt = {16'h0000, REVISION};
        sps_pkg::ADDR_STS: rdata_nxt = {16'h0000, sts_word};
        default:
        begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = sps_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // per-pin override mux; uncovered bits always pass the normal drive
  for (genvar i = 0; i < 16; i++)
  begin : g_pin
    always_comb
    begin
      if (sps_pkg::PIN_MASK[i] && susp_act)
      begin
        // open drain pulls low or floats, active drive follows level
        pin_out_nxt[i] = level_r[i] && !mode_r[i];
        pin_oe_nxt[i] = !mode_r[i] || !level_r[i];
      end
      else
      begin
        pin_out_nxt[i] = normal_out[i];
        pin_oe_nxt[i] = normal_oe[i];
      end
    end
  end

  // indicator trigger; codes 000 and 100 are both active high
  always_comb
  begin
    unique case (indicator_b_select_r)
      sps_pkg::SEL_SR_HI, sps_pkg::SEL_SR_HI2:
        ind_active = usb_suspend || usb_bus_reset;
      sps_pkg::SEL_S_HI, sps_pkg::SEL_S_LO:
        ind_active = usb_suspend;
      sps_pkg::SEL_C_HI, sps_pkg::SEL_C_LO:
        ind_active = usb_suspend ||
                     (high_power && !usb_configured);
      sps_pkg::SEL_R_HI, sps_pkg::SEL_R_LO:
        ind_active = usb_bus_reset;
    endcase
    ind_level = ind_active;
    if (indicator_b_select_r == sps_pkg::SEL_S_LO ||
        indicator_b_select_r == sps_pkg::SEL_C_LO ||
        indicator_b_select_r == sps_pkg::SEL_R_LO)
      ind_level = !ind_active;
    if (indicator_b_drive_r == sps_pkg::DRV_OD)
    begin
      ind_out_nxt = 1'b0;
      ind_oe_nxt = !ind_level;
    end
    else
    begin
      ind_out_nxt = ind_level;
      ind_oe_nxt = 1'b1;
    end
  end

  // all state registered; pin drive flops give one clean edge on resume
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      level_r <= sps_pkg::LEVEL_RST;
      mode_r <= sps_pkg::MODE_RST;
      indicator_b_select_r <= sps_pkg::SEL_RST;
      indicator_b_drive_r <= sps_pkg::DRV_RST;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 16'h0000;
      wstrb_r <= 2'h0;
      bvalid_r <= 1'b0;
      bresp_r <= sps_pkg::RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= sps_pkg::RESP_OKAY;
      pin_out_r <= 16'h0000;
      pin_oe_r <= 16'h0000;
      ind_out_r <= 1'b0;
      ind_oe_r <= 1'b0;
    end
    else
    begin
      level_r <= level_nxt;
      mode_r <= mode_nxt;
      indicator_b_select_r <= sel_nxt;
      indicator_b_drive_r <= drv_nxt;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
      ind_out_r <= ind_out_nxt;
      ind_oe_r <= ind_oe_nxt;
    end
  end

  // checks on the override, the indicator and the bus
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_hold_normal: assert property (
    usb_suspend && !mode_r[sps_pkg::EN_BIT] |=>
      pin_out_r == $past(normal_out) && pin_oe_r == $past(normal_oe))
    else $error("pins not held in suspend with override off");
  chk_ovr_level: assert property (
    susp_act |=> (pin_out_r & sps_pkg::PIN_MASK) ==
      ($past(level_r & ~mode_r) & sps_pkg::PIN_MASK))
    else $error("override level wrong");
  chk_ovr_drive: assert property (
    susp_act |=> (pin_oe_r & sps_pkg::PIN_MASK) ==
      ($past(~mode_r | ~level_r) & sps_pkg::PIN_MASK))
    else $error("override drive type wrong");
  chk_rsvd_zero: assert property (
    (level_r & ~sps_pkg::PIN_MASK) == 16'h0000 &&
    (mode_r & ~sps_pkg::MODE_MASK) == 16'h0000)
    else $error("reserved bits stored");
  chk_state_read: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == sps_pkg::ADDR_STS
    |=> rvalid_r && rdata_r[sps_pkg::STATE_BIT] == $past(sy2_r))
    else $error("pin b state readback wrong");
  chk_rst_high: assert property (
    indicator_b_select_r == sps_pkg::SEL_R_HI &&
    indicator_b_drive_r == sps_pkg::DRV_PP |=>
      ind_out_r == $past(usb_bus_reset))
    else $error("pin b not following bus reset");
  chk_susp_low: assert property (
    indicator_b_select_r == sps_pkg::SEL_S_LO &&
    indicator_b_drive_r == sps_pkg::DRV_PP |=>
      ind_out_r == !$past(usb_suspend))
    else $error("pin b not low in suspend");
  chk_cfg_high: assert property (
    indicator_b_select_r == sps_pkg::SEL_C_HI &&
    indicator_b_drive_r == sps_pkg::DRV_PP && !usb_suspend |=>
      ind_out_r == $past(high_power && !usb_configured))
    else $error("pin b unconfigured indication wrong");
  chk_od_drive: assert property (
    indicator_b_drive_r == sps_pkg::DRV_OD |=> !ind_out_r)
    else $error("open drain pin b driven high");
  chk_resume_pins: assert property (
    $fell(usb_suspend) |=> pin_out_r == $past(normal_out)
      && pin_oe_r == $past(normal_oe))
    else $error("pins not restored on resume");
  chk_write_resp: assert property (
    aw_hold_r && w_hold_r && !bvalid_r |=> bvalid_r[*1] ##0
      !aw_hold_r)
    else $error("write response missing");

  cov_override: cover property (susp_act ##1 !usb_suspend);
  cov_od_pin_b: cover property (
    indicator_b_drive_r == sps_pkg::DRV_OD && ind_oe_r);
  cov_write_done: cover property (bvalid_r && s_axi_bready);
  cov_read_sts: cover property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == sps_pkg::ADDR_STS);

endmodule : sps_suspend_pins

// file: sps_pkg.sv
// constants of the suspend pin override and usb indicator block
// assumes a 32-bit axi4-lite slave with word-indexed register offsets
package sps_pkg;
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_LEVEL = 12'h06a;
  localparam logic [11:0] IDX_MODE = 12'h06b;
  localparam logic [11:0] IDX_REV = 12'h260;
  localparam logic [11:0] IDX_STS = 12'h262;
  localparam int ADDR_W = 14;
  localparam logic [13:0] ADDR_LEVEL = {IDX_LEVEL, 2'b00};
  localparam logic [13:0] ADDR_MODE = {IDX_MODE, 2'b00};
  localparam logic [13:0] ADDR_REV = {IDX_REV, 2'b00};
  localparam logic [13:0] ADDR_STS = {IDX_STS, 2'b00};
  // covered pins: modem 13:10, transmit 7:6, direction/flow/clock 3:0
  localparam logic [15:0] PIN_MASK = 16'h3ccf;
  localparam int EN_BIT = 15;
  localparam logic [15:0] MODE_MASK = PIN_MASK | (16'h0001 << EN_BIT);
  localparam logic [15:0] LEVEL_RST = 16'h0000;
  localparam logic [15:0] MODE_RST = 16'h0000;
  // usb indicator control fields
  localparam int STATE_BIT = 13;
  localparam int SEL_LSB = 10;
  localparam int DRV_LSB = 8;
  localparam logic [2:0] SEL_RST = 3'h0;
  localparam logic [1:0] DRV_OD = 2'h1;
  localparam logic [1:0] DRV_PP = 2'h2;
  localparam logic [1:0] DRV_RST = DRV_PP;
  // indicator selector codes
  localparam logic [2:0] SEL_SR_HI = 3'h0;
  localparam logic [2:0] SEL_S_HI = 3'h1;
  localparam logic [2:0] SEL_C_HI = 3'h2;
  localparam logic [2:0] SEL_R_HI = 3'h3;
  localparam logic [2:0] SEL_SR_HI2 = 3'h4;
  localparam logic [2:0] SEL_S_LO = 3'h5;
  localparam logic [2:0] SEL_C_LO = 3'h6;
  localparam logic [2:0] SEL_R_LO = 3'h7;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sps_pkg

// file: sps_board_model.sv
// board circuitry around usb indicator pin b: one pull-up resistor
// assumes the design splits the pin into out, enable and readback
`timescale 1ns/1ps
module sps_board_model (
  input wire logic pin_b_out,
  input wire logic pin_b_oe,
  output logic pin_b_level
);
  // a released pin floats up through the pull-up, so open drain reads high
  assign pin_b_level = pin_b_oe ? pin_b_out : 1'b1;
endmodule : sps_board_model

// file: suspend_pin_override_status_tb.sv
// testbench of the suspend pin override and usb indicator block
// assumes sps_pkg, the design and the board model are compiled first
`timescale 1ns/1ps
module suspend_pin_override_status_tb;
  localparam logic [15:0] REV = 16'h5a3c; // arbitrary value
  localparam logic [15:0] LVL = 16'h24c5;
  localparam logic [15:0] TYP = 16'h1443;
  // {sel, suspend, bus reset, configured, high power, pin level}
  localparam logic [7:0] ROWS [17] = '{8'h15, 8'h0d, 8'h04, 8'h35, 8'h2c,
    8'h43, 8'h40, 8'h55, 8'h6d, 8'h74, 8'h8d, 8'hb4, 8'ha5, 8'hc2, 8'hc7,
    8'hec, 8'hf5};
  logic aclk, aresetn;
  logic [13:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic usb_suspend, usb_bus_reset, usb_configured, high_power;
  logic [15:0] normal_out, normal_oe, pin_out, pin_oe;
  logic usb_indicator_pin_b_in, usb_indicator_pin_b_out;
  logic usb_indicator_pin_b_oe;
  logic [31:0] rd;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;

  sps_suspend_pins #(.REVISION(REV)) i_dut (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .usb_suspend, .usb_bus_reset,
    .usb_configured, .high_power, .normal_out, .normal_oe, .pin_out,
    .pin_oe, .usb_indicator_pin_b_in, .usb_indicator_pin_b_out,
    .usb_indicator_pin_b_oe);

  sps_board_model i_board (.pin_b_out(usb_indicator_pin_b_out),
    .pin_b_oe(usb_indicator_pin_b_oe), .pin_b_level(usb_indicator_pin_b_in));

  // free-running 100 mhz clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      error_cnt = error_cnt + 1;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // handshakes are judged mid-cycle so the taking edge is known for sure
  task automatic axi_write(input logic [13:0] a, input logic [15:0] d,
    input logic [3:0] strb);
    logic aw_hit, w_hit, b_hit;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= strb;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b_hit = 1'b0;
    while (!b_hit)
    begin
      @(negedge aclk);
      aw_hit = s_axi_awvalid && s_axi_awready;
      w_hit = s_axi_wvalid && s_axi_wready;
      b_hit = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw_hit)
        s_axi_awvalid <= 1'b0;
      if (w_hit)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic read_expect(input logic [13:0] a, input logic [31:0] e,
    input logic [1:0] er);
    logic ar_hit, r_hit;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r_hit = 1'b0;
    while (!r_hit)
    begin
      @(negedge aclk);
      ar_hit = s_axi_arvalid && s_axi_arready;
      r_hit = s_axi_rvalid;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar_hit)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    check(rd, e);
    check({30'h0, resp}, {30'h0, er});
  endtask : read_expect

  // pins are registered, so two edges after a change they have settled
  task automatic pins_expect(input logic [15:0] eo, input logic [15:0] ee);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    check({16'h0, pin_out}, {16'h0, eo});
    check({16'h0, pin_oe}, {16'h0, ee});
    @(posedge aclk);
  endtask : pins_expect

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  // main sequence: selector table first, then reset and awkward cases
  initial
  begin
    logic [7:0] row;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_wdata, s_axi_wstrb} = '0;
    {usb_suspend, usb_bus_reset, high_power} = '0;
    usb_configured = 1'b1;
    normal_out = 16'h5555;
    normal_oe = 16'hffff;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 17; i++)
    begin
      row = ROWS[i];
      usb_suspend <= row[4];
      usb_bus_reset <= row[3];
      usb_configured <= row[2];
      high_power <= row[1];
      axi_write(sps_pkg::ADDR_STS, {3'b000, row[7:5], 2'b10, 8'h00}, 4'h3);
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      check({31'h0, usb_indicator_pin_b_out}, {31'h0, row[0]});
      check({31'h0, usb_indicator_pin_b_oe}, 32'h1);
      read_expect(sps_pkg::ADDR_STS, {18'h0, row[0], row[7:5], 10'h200},
        sps_pkg::RESP_OKAY);
    end
    // second reset in mid-run, then reset values and bus corner cases
    usb_suspend <= 1'b0;
    usb_bus_reset <= 1'b0;
    usb_configured <= 1'b1;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    read_expect(sps_pkg::ADDR_LEVEL, 32'h0, sps_pkg::RESP_OKAY);
    read_expect(sps_pkg::ADDR_MODE, 32'h0, sps_pkg::RESP_OKAY);
    read_expect(sps_pkg::ADDR_STS, 32'h0200, sps_pkg::RESP_OKAY);
    axi_write(sps_pkg::ADDR_REV, 16'hffff, 4'h3);
    check({30'h0, resp}, {30'h0, sps_pkg::RESP_OKAY});
    read_expect(sps_pkg::ADDR_REV, {16'h0, REV}, sps_pkg::RESP_OKAY);
    read_expect(14'h0004, 32'h0, sps_pkg::RESP_SLVERR);
    axi_write(14'h0010, 16'h1234, 4'h3);
    check({30'h0, resp}, {30'h0, sps_pkg::RESP_SLVERR});
    axi_write(sps_pkg::ADDR_LEVEL, 16'hffff, 4'h3);
    read_expect(sps_pkg::ADDR_LEVEL, 32'h3ccf, sps_pkg::RESP_OKAY);
    axi_write(sps_pkg::ADDR_LEVEL, 16'h0000, 4'h1);
    read_expect(sps_pkg::ADDR_LEVEL, 32'h3c00, sps_pkg::RESP_OKAY);
    axi_write(sps_pkg::ADDR_MODE, 16'hffff, 4'h3);
    read_expect(sps_pkg::ADDR_MODE, 32'hbccf, sps_pkg::RESP_OKAY);
    axi_write(sps_pkg::ADDR_STS, 16'h0400, 4'h3);
    read_expect(sps_pkg::ADDR_STS, 32'h0600, sps_pkg::RESP_OKAY);
    // drive code 11 is refused while the select lands; low strobe alone
    // must leave both indicator fields untouched
    axi_write(sps_pkg::ADDR_STS, 16'h0f00, 4'h3);
    read_expect(sps_pkg::ADDR_STS, 32'h0e00, sps_pkg::RESP_OKAY);
    axi_write(sps_pkg::ADDR_STS, 16'h1500, 4'h1);
    read_expect(sps_pkg::ADDR_STS, 32'h0e00, sps_pkg::RESP_OKAY);
    // suspend with the override off, on, then resume
    axi_write(sps_pkg::ADDR_LEVEL, LVL, 4'h3);
    axi_write(sps_pkg::ADDR_MODE, TYP, 4'h3);
    usb_suspend <= 1'b1;
    pins_expect(16'h5555, 16'hffff);
    axi_write(sps_pkg::ADDR_MODE, TYP | 16'h8000, 4'h3);
    pins_expect((16'h5555 & ~sps_pkg::PIN_MASK) |
      (LVL & ~TYP & sps_pkg::PIN_MASK),
      ~sps_pkg::PIN_MASK | ((~TYP | ~LVL) & sps_pkg::PIN_MASK));
    usb_suspend <= 1'b0;
    pins_expect(16'h5555, 16'hffff);
    // open drain indicator released in suspend reads high via the pull-up
    axi_write(sps_pkg::ADDR_STS, 16'h0500, 4'h3);
    usb_suspend <= 1'b1;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    check({31'h0, usb_indicator_pin_b_oe}, 32'h0);
    read_expect(sps_pkg::ADDR_STS, 32'h2500, sps_pkg::RESP_OKAY);
    complete_run();
  end
endmodule : suspend_pin_override_status_tb
